/* File: logic/ddr_mode_defines.vh */
// constants for the mode-register configuration block
`ifndef DDR_MODE_DEFINES_VH
`define DDR_MODE_DEFINES_VH
// command encodings {cs_n, ras_n, cas_n, we_n}
`define CMD_LOAD_MODE      4'h0
`define CMD_READ           4'h5
`define CMD_WRITE          4'h4
`define CMD_REFRESH        4'h1
// bank selects
`define SEL_BASE           2'h0
`define SEL_EXT            2'h1
// base register fields
`define BL_LSB             0
`define BL_MSB             2
`define BT_BIT             3
`define RL_LSB             4
`define RL_MSB             6
`define OP_LSB             7
`define OP_MSB             12
`define DLL_RST_BIT        8
// extended register fields
`define EXT_DLL_DIS_BIT    0
`define EXT_DRIVE_BIT      1
// burst length codes
`define BL_CODE_2          3'h1
`define BL_CODE_4          3'h2
`define BL_CODE_8          3'h3
// read latency codes (half-clock units: 4, 5, 6)
`define RL_CODE_2          3'h2
`define RL_CODE_3          3'h3
`define RL_CODE_25         3'h6
// operating mode codes
`define OP_NORMAL          6'h00
`define OP_DLL_RESET       6'h02
// reset values
`define BASE_RESET         13'h0000
`define EXT_RESET          13'h0000
// dll lock wait
`define DLL_LOCK_CYCLES    200
`endif

/* File: logic/burst_order_gen.v */
// burst column order generator
`default_nettype none
module burst_order_gen (
  // burst setup
  input  wire [2:0] start_offset,
  input  wire [2:0] length_mask,
  input  wire       burst_order_select_bit,
  input  wire [2:0] beat,
  // resulting offset
  output wire [2:0] offset
);
  wire [2:0] seq_offset;
  wire [2:0] int_offset;
  // sequential adds modulo length, interleaved xors the count  see R8
  assign seq_offset = (start_offset + beat) & length_mask;
  assign int_offset = (start_offset ^ beat) & length_mask;
  assign offset     = burst_order_select_bit ? int_offset : seq_offset;
endmodule // burst_order_gen
`default_nettype wire

/* File: logic/read_latency_pipe.v */
// read latency delay line in half-clock units
`default_nettype none
module read_latency_pipe #(
  parameter DEPTH = 8
) (
  // clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // launch
  input  wire       launch,
  input  wire [2:0] half_clocks,
  // result
  output reg        due_full,
  output reg        due_half
);
  reg [DEPTH-1:0] shift;
  always @(posedge clk) begin
    if (!rst_n) begin
      shift <= {DEPTH{1'b0}};
    end else begin
      shift <= {shift[DEPTH-2:0], launch};
    end
  end
  // the half-clock setting lands half a clock late, flagged as half  see R9
  always @* begin
    due_full = 1'b0;
    due_half = 1'b0;
    case (half_clocks)
      3'h4: due_full = shift[1];
      3'h5: due_half = shift[2];
      3'h6: due_full = shift[2];
      default: due_full = 1'b0;
    endcase
  end
endmodule // read_latency_pipe
`default_nettype wire

/* File: logic/ddr_mode_config.v */
// mode and extended mode register configuration of the ddr device
// Summary of operation
// R1: load mode with banks 00 writes base
// R2: base holds; dll reset bit self-clears
// R3: rewrite never touches array contents
// R4: controller writes only when idle
// R5: fields: length, type, latency, mode
// R6: lengths 2, 4, 8 for reads, writes
// R7: upper column bits pick aligned block
// R8: sequential adds, interleaved xors offset
// R9: first data at edge n plus m
// R10: controller picks latency for its frequency
// R11: controller avoids reserved codes
// R12: mode zero selects normal operation
// R13: mode 000010 starts dll reset
// R14: follow dll reset with normal write
// R15: controller writes only defined mode codes
// R16: banks 01 write the extended register
// R17: enable dll then reset via base
// R18: extended write only when idle
// R19: controller keeps dll enabled
// R20: self-refresh exit enables dll
// R21: wait 200 cycles before read
// R22: address carries op-code, other selects reserved
// R23: wait counted from enabling command
`default_nettype none
`include "ddr_mode_defines.vh"
module ddr_mode_config #(
  parameter COL_WIDTH = 10
) (
  // clock and reset
  input  wire                 clk,
  input  wire                 rst_n,
  // command pins
  input  wire                 cs_n,
  input  wire                 ras_n,
  input  wire                 cas_n,
  input  wire                 we_n,
  input  wire                 cke,
  input  wire [1:0]           bank_sel,
  input  wire [12:0]          addr,
  // configuration seen by the burst and data logic
  output reg  [12:0]          burst_latency_operating_register,
  output reg  [12:0]          ext_mode,
  output reg  [2:0]           burst_length,
  output reg                  burst_order_select_bit,
  output reg  [2:0]           read_latency_setting,
  output reg                  dll_enabled,
  output reg                  dll_reset_pulse,
  output reg                  dll_locked,
  output reg                  config_error,
  // burst sequencing
  output reg                  burst_active,
  output reg                  burst_is_read,
  output reg  [COL_WIDTH-1:0] burst_col,
  output reg                  read_data_due,
  output reg                  read_data_half
);
  // pins come from outside this clock domain: two-flop synchronisers
  // reset values decode as deselect, so reset release never fakes a command
  reg        cs_n_meta;
  reg        cs_n_sync;
  reg        ras_n_meta;
  reg        ras_n_sync;
  reg        cas_n_meta;
  reg        cas_n_sync;
  reg        we_n_meta;
  reg        we_n_sync;
  reg [1:0]  sel_meta;
  reg [1:0]  sel_sync;
  reg [12:0] addr_meta;
  reg [12:0] addr_sync;
  always @(posedge clk) begin
    if (!rst_n) begin
      cs_n_meta  <= 1'b1;
      cs_n_sync  <= 1'b1;
      ras_n_meta <= 1'b1;
      ras_n_sync <= 1'b1;
      cas_n_meta <= 1'b1;
      cas_n_sync <= 1'b1;
      we_n_meta  <= 1'b1;
      we_n_sync  <= 1'b1;
      sel_meta   <= 2'h0;
      sel_sync   <= 2'h0;
      addr_meta  <= 13'h0000;
      addr_sync  <= 13'h0000;
    end else begin
      cs_n_meta  <= cs_n;
      cs_n_sync  <= cs_n_meta;
      ras_n_meta <= ras_n;
      ras_n_sync <= ras_n_meta;
      cas_n_meta <= cas_n;
      cas_n_sync <= cas_n_meta;
      we_n_meta  <= we_n;
      we_n_sync  <= we_n_meta;
      sel_meta   <= bank_sel;
      sel_sync   <= sel_meta;
      addr_meta  <= addr;
      addr_sync  <= addr_meta;
    end
  end

  // cke has a third stage for edges; reset to its idle high level, so no false edge
  reg        cke_meta;
  reg        cke_sync;
  reg        cke_prev;
  always @(posedge clk) begin
    if (!rst_n) begin
      cke_meta <= 1'b1;
      cke_sync <= 1'b1;
      cke_prev <= 1'b1;
    end else begin
      cke_meta <= cke;
      cke_sync <= cke_meta;
      cke_prev <= cke_sync;
    end
  end

  wire [3:0]  cmd  = {cs_n_sync, ras_n_sync, cas_n_sync, we_n_sync};
  wire [1:0]  sel  = sel_sync;
  wire [12:0] code = addr_sync;
  wire        load_cmd  = cke_sync && (cmd == `CMD_LOAD_MODE);
  wire        read_cmd  = cke_sync && (cmd == `CMD_READ);
  wire        write_cmd = cke_sync && (cmd == `CMD_WRITE);
  wire        base_load = load_cmd && (sel == `SEL_BASE);
  wire        ext_load  = load_cmd && (sel == `SEL_EXT);

  // refresh with cke falling enters self refresh; cke rising again leaves it
  reg         in_self_refresh;
  wire        sr_exit = in_self_refresh && cke_sync && !cke_prev;

  // decode functions used by the load check and by the burst and read latency logic
  function [2:0] len_mask;
    input [2:0] bl;
    begin
      case (bl)
        `BL_CODE_2: len_mask = 3'h1;
        `BL_CODE_4: len_mask = 3'h3;
        `BL_CODE_8: len_mask = 3'h7;
        default:    len_mask = 3'h0;
      endcase
    end
  endfunction
  function [2:0] half_clocks;
    input [2:0] rl;
    begin
      case (rl)
        `RL_CODE_2:  half_clocks = 3'h4;
        `RL_CODE_25: half_clocks = 3'h5;
        `RL_CODE_3:  half_clocks = 3'h6;
        default:     half_clocks = 3'h0;
      endcase
    end
  endfunction

  wire [5:0] op_field = code[`OP_MSB:`OP_LSB];
  wire       code_ok  = (len_mask(code[`BL_MSB:`BL_LSB]) != 3'h0) &&
                        (half_clocks(code[`RL_MSB:`RL_LSB]) != 3'h0) &&
                        ((op_field == `OP_NORMAL) || (op_field == `OP_DLL_RESET));

  // base register; no path reaches the array, so contents survive  see R3
  always @(posedge clk) begin
    if (!rst_n) begin
      burst_latency_operating_register <= `BASE_RESET;
      dll_reset_pulse                  <= 1'b0;
      config_error                     <= 1'b0;
    end else begin
      dll_reset_pulse <= 1'b0;
      if (base_load) begin // see R1 see R22
        // dll reset bit is acted on now and never stored  see R2 see R13
        burst_latency_operating_register <= code & ~(13'h0001 << `DLL_RST_BIT);
        dll_reset_pulse <= (op_field == `OP_DLL_RESET); // see R12
        // reserved codes are stored anyway; flagged for the system  see R11 see R15
        config_error <= !code_ok;
      end
    end
  end

  // extended register; the two reserved bank selects are ignored  see R22
  always @(posedge clk) begin
    if (!rst_n) begin
      ext_mode <= `EXT_RESET;
    end else if (ext_load) begin // see R16
      ext_mode <= code;
    end
  end

  // field decode of the held register  see R5
  always @* begin
    burst_length           = burst_latency_operating_register[`BL_MSB:`BL_LSB];
    burst_order_select_bit = burst_latency_operating_register[`BT_BIT];
    read_latency_setting   = burst_latency_operating_register[`RL_MSB:`RL_LSB];
  end

  // self refresh entry on refresh with cke falling, exit on cke rising
  always @(posedge clk) begin
    if (!rst_n) begin
      in_self_refresh <= 1'b0;
    end else if ((cmd == `CMD_REFRESH) && !cke_sync && cke_prev) begin
      in_self_refresh <= 1'b1;
    end else if (sr_exit) begin
      in_self_refresh <= 1'b0;
    end
  end

  // dll state: extended bit low enables it, self-refresh exit forces it on
  always @(posedge clk) begin
    if (!rst_n) begin
      dll_enabled <= 1'b0;
    end else if (sr_exit) begin
      dll_enabled <= 1'b1; // see R20
    end else if (ext_load) begin
      dll_enabled <= !code[`EXT_DLL_DIS_BIT]; // see R19
    end
  end

  // lock is informational; counting restarts at the enabling command, at self-refresh exit and at each dll reset  see R21 see R23
  wire      dll_restart = sr_exit || dll_reset_pulse ||
                          (ext_load && !code[`EXT_DLL_DIS_BIT] && !dll_enabled);
  reg [7:0] lock_count;
  always @(posedge clk) begin
    if (!rst_n) begin
      dll_locked <= 1'b0;
      lock_count <= 8'h00;
    end else if (dll_restart) begin
      lock_count <= 8'h00;
      dll_locked <= 1'b0;
    end else if (!dll_enabled) begin
      dll_locked <= 1'b0;
    end else if (lock_count != (`DLL_LOCK_CYCLES - 1)) begin
      lock_count <= lock_count + 8'h01;
    end else begin
      dll_locked <= 1'b1;
    end
  end

  // burst sequencing
  wire [2:0] mask = len_mask(burst_length);
  reg  [2:0] beat;
  reg  [2:0] start_off;
  reg  [COL_WIDTH-1:0] block_base;
  wire [2:0] offset;
  burst_order_gen u_order (
    .start_offset           (start_off),
    .length_mask            (mask),
    .burst_order_select_bit (burst_order_select_bit),
    .beat                   (beat),
    .offset                 (offset)
  );
  always @(posedge clk) begin
    if (!rst_n) begin
      burst_active  <= 1'b0;
      burst_is_read <= 1'b0;
      beat          <= 3'h0;
      start_off     <= 3'h0;
      block_base    <= {COL_WIDTH{1'b0}};
    end else if ((read_cmd || write_cmd) && (mask != 3'h0)) begin // see R6
      // aligned block from upper bits, start from the low ones  see R7
      burst_active  <= 1'b1;
      burst_is_read <= read_cmd;
      beat          <= 3'h0;
      start_off     <= code[2:0] & mask;
      block_base    <= code[COL_WIDTH-1:0] & ~{{(COL_WIDTH-3){1'b0}}, mask};
    end else if (burst_active) begin
      // one column per beat; length bounds the accesses  see R6
      if (beat == mask) begin
        burst_active <= 1'b0;
      end else begin
        beat <= beat + 3'h1;
      end
    end
  end
  always @* begin
    burst_col = block_base | {{(COL_WIDTH-3){1'b0}}, offset};
  end

  // first read data relative to the registered read  see R9 see R10
  // the read registers on the edge that starts the burst; data lands m edges on
  wire due_full;
  wire due_half;
  read_latency_pipe #(
    .DEPTH (8)
  ) u_latency (
    .clk         (clk),
    .rst_n       (rst_n),
    .launch      (read_cmd),
    .half_clocks (half_clocks(read_latency_setting)),
    .due_full    (due_full),
    .due_half    (due_half)
  );
  always @(posedge clk) begin
    if (!rst_n) begin
      read_data_due  <= 1'b0;
      read_data_half <= 1'b0;
    end else begin
      read_data_due  <= due_full | due_half;
      read_data_half <= due_half;
    end
  end
endmodule // ddr_mode_config
`default_nettype wire

/* File: verif/ddr_ctrl_model.sv */
// controller model placing commands on the pins
`default_nettype none
module ddr_ctrl_model (
  // request from the bench
  input  wire logic        go,
  input  wire logic [3:0]  cmd,
  input  wire logic [1:0]  bank,
  input  wire logic [12:0] code,
  // command pins
  output logic             cs_n,
  output logic             ras_n,
  output logic             cas_n,
  output logic             we_n,
  output logic [1:0]       bank_sel,
  output logic [12:0]      addr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [17:0] last = 18'h00000;
  // idle pins invert the last command so no stale copy decodes
  always @(negedge go) last <= {cmd[2:0], bank, code};
  assign {cs_n, ras_n, cas_n, we_n, bank_sel, addr} =
    go ? {cmd, bank, code} : {1'b1, ~last};
endmodule // ddr_ctrl_model
`default_nettype wire

/* File: verif/ddr_mode_config_assertions.sv */
// port checks for the mode register block
`default_nettype none
`include "ddr_mode_defines.vh"
module ddr_mode_config_assertions #(
  parameter COL_WIDTH = 10
) (
  // clock, reset, pins
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire logic                 cs_n,
  input wire logic                 ras_n,
  input wire logic                 cas_n,
  input wire logic                 we_n,
  input wire logic                 cke,
  input wire logic [1:0]           bank_sel,
  // outputs
  input wire logic [12:0]          burst_latency_operating_register,
  input wire logic [12:0]          ext_mode,
  input wire logic [2:0]           burst_length,
  input wire logic                 burst_order_select_bit,
  input wire logic [2:0]           read_latency_setting,
  input wire logic                 dll_reset_pulse,
  input wire logic                 dll_locked,
  input wire logic                 burst_active,
  input wire logic [COL_WIDTH-1:0] burst_col,
  input wire logic                 read_data_half
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire [12:0] mq = burst_latency_operating_register;
  wire        ld = !cs_n && !ras_n && !cas_n && !we_n && cke;
  wire        ldb = ld && bank_sel == `SEL_BASE;
  wire        lde = ld && bank_sel == `SEL_EXT;
  a_field_map: assert property (
    {read_latency_setting, burst_order_select_bit, burst_length} == mq[6:0])
    else $error("fields differ from stored mode");
  a_dll_bit_clear: assert property (!mq[`DLL_RST_BIT])
    else $error("dll reset bit stored");
  a_base_hold: assert property (!$stable(mq) && $past(rst_n) |->
    $past(ldb, 2) || $past(ldb, 3) || $past(ldb, 4))
    else $error("base changed without load");
  a_ext_hold: assert property (!$stable(ext_mode) && $past(rst_n) |->
    $past(lde, 2) || $past(lde, 3) || $past(lde, 4))
    else $error("extended changed without load");
  a_pulse_single: assert property (dll_reset_pulse |=> !dll_reset_pulse)
    else $error("dll reset pulse too long");
  a_lock_wait: assert property (dll_reset_pulse |-> ##2 !dll_locked [*8])
    else $error("lock too early");
  a_block_fixed: assert property (burst_active && $past(burst_active) |->
    burst_col[COL_WIDTH-1:3] == $past(burst_col[COL_WIDTH-1:3]))
    else $error("burst left its block");
  a_seq_step: assert property (burst_active && $past(burst_active) &&
    !burst_order_select_bit && burst_length == `BL_CODE_8 |->
    burst_col[2:0] == $past(burst_col[2:0]) + 3'h1)
    else $error("sequential beat skipped");
  a_half_case: assert property (read_data_half |->
    read_latency_setting == `RL_CODE_25)
    else $error("half marker on whole latency");
  c_dll_reset: cover property (dll_reset_pulse);
  c_half: cover property (read_data_half);
  c_interleave: cover property (burst_active && burst_order_select_bit);
endmodule // ddr_mode_config_assertions
bind ddr_mode_config ddr_mode_config_assertions #(.COL_WIDTH(COL_WIDTH))
  ddr_mode_config_assertions_inst (.*);
`default_nettype wire

/* File: verif/ddr_mode_register_config_bench.sv */
// self-checking bench for the mode register block
`default_nettype none
`include "ddr_mode_defines.vh"
module ddr_mode_register_config_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cke = 1'b1;
  logic        go = 1'b0;
  logic [3:0]  cmd = 4'h0;
  logic [1:0]  bank = 2'h0;
  logic [12:0] code = 13'h0000;
  wire         cs_n, ras_n, cas_n, we_n, burst_order_select_bit, dll_enabled;
  wire         dll_reset_pulse, dll_locked, config_error, burst_active;
  wire         burst_is_read, read_data_due, read_data_half;
  wire [1:0]   bank_sel;
  wire [2:0]   burst_length, read_latency_setting;
  wire [9:0]   burst_col;
  wire [12:0]  addr, burst_latency_operating_register, ext_mode;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          seed = 32'hf02c9024;
  ddr_ctrl_model ddr_ctrl_model_inst (.*);
  ddr_mode_config ddr_mode_config_inst (.*);
  always #20 clk = ~clk;
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
                      input int w);
    @(negedge clk);
    cmd = c;
    bank = b;
    code = a;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    repeat (w) @(negedge clk);
  endtask
  task automatic mode(input logic [12:0] a);
    send(`CMD_LOAD_MODE, `SEL_BASE, a, 5);
  endtask
  task automatic rd(input logic [2:0] bl, input logic t, input logic [2:0] cl);
    logic [9:0] s;
    logic [2:0] m;
    int         lat;
    int         j;
    s = 10'($random(seed));
    m = (3'h1 << bl) - 3'h1;
    lat = (cl == `RL_CODE_2) ? 2 : 3;
    mode({6'h00, cl, t, bl});
    send(`CMD_READ, 2'h0, {3'h0, s}, 0);
    for (j = 0; j < 12 && burst_active !== 1'b1; j++) @(negedge clk);
    if (burst_active !== 1'b1) begin
      chk(burst_active, 1'b1);
      give_verdict;
    end
    for (j = 0; j < 10; j++) begin
      chk({burst_active, read_data_due}, {j < (1 << bl), j == lat});
      if (j < (1 << bl))
        chk(burst_col, {s[9:3], (s[2:0] & ~m) | ((t ? (s[2:0] ^ j[2:0]) :
            (s[2:0] + j[2:0])) & m)});
      if (j == lat)
        chk(read_data_half, cl == `RL_CODE_25);
      @(negedge clk);
    end
  endtask
  task automatic note(input string s);
    $display("%s done, checks %0d", s, samples_checked);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    logic [2:0] cls [3];
    int         i;
    int         k;
    cls = '{`RL_CODE_2, `RL_CODE_25, `RL_CODE_3};
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    chk(burst_latency_operating_register, `BASE_RESET);
    chk(ext_mode, `EXT_RESET);
    send(`CMD_LOAD_MODE, `SEL_EXT, 13'h0000, 5);
    chk(dll_enabled, 1'b1);
    send(`CMD_LOAD_MODE, `SEL_BASE, 13'h0122, 0);
    k = 0;
    for (i = 0; i < 8; i++) begin
      @(negedge clk);
      k += dll_reset_pulse;
    end
    chk(13'(k), 13'h0001);
    chk(burst_latency_operating_register, 13'h0022);
    mode(13'h0022);
    repeat (120) @(negedge clk);
    chk(dll_locked, 1'b0);
    for (i = 0; i < 200 && dll_locked !== 1'b1; i++) @(negedge clk);
    chk(dll_locked, 1'b1);
    if (dll_locked !== 1'b1)
      give_verdict;
    note("dll");
    for (i = 0; i < 18; i++) rd(3'(i % 3 + 1), i >= 9, cls[(i / 3) % 3]);
    note("bursts");
    send(`CMD_LOAD_MODE, 2'h2, 13'h1fff, 5);
    chk(burst_latency_operating_register, 13'h003b);
    chk(ext_mode, 13'h0000);
    mode(13'h0038);
    chk(config_error, 1'b1);
    mode(13'h003b);
    chk(config_error, 1'b0);
    note("reserved");
    send(`CMD_LOAD_MODE, `SEL_EXT, 13'h0001, 5);
    chk(dll_enabled, 1'b0);
    @(negedge clk);
    cke = 1'b0;
    cmd = `CMD_REFRESH;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    repeat (6) @(negedge clk);
    cke = 1'b1;
    repeat (6) @(negedge clk);
    chk(dll_enabled, 1'b1);
    note("self refresh");
    give_verdict;
  end
endmodule // ddr_mode_register_config_bench
`default_nettype wire
